// >>> include/sci_map.vh
// Register map and constants for the two-channel serial pin block.
// Assumes an 8-bit register port; each channel owns eight addresses.
`ifndef SCI_MAP_VH
`define SCI_MAP_VH
// Register port widths
`define SCI_ADDR_W      4
`define SCI_DATA_W      8
// Register index within a channel (address bit 3 picks the channel)
`define SCI_REG_CTRL    3'h0
`define SCI_REG_TXDATA  3'h1
`define SCI_REG_RXDATA  3'h2
`define SCI_REG_STATUS  3'h3
`define SCI_REG_AUX     3'h4
// Reset values
`define SCI_CTRL_RST    8'h00
`define SCI_AUX_RST     8'h00
// Control field positions
`define SCI_C_MODE_LO   0
`define SCI_C_FAC_LO    2
`define SCI_C_RXEN      4
`define SCI_C_DTR       5
`define SCI_C_WREN      6
`define SCI_C_WRFN      7
// Aux field positions
`define SCI_A_WRDIR     0
`define SCI_A_SYNC      1
// Status field positions
`define SCI_S_TXFULL    0
`define SCI_S_RXFULL    1
`define SCI_S_TXBUSY    2
`define SCI_S_RXBUSY    3
`define SCI_S_OVR       4
`define SCI_S_FRM       5
`define SCI_S_CLEAR     6
`define SCI_S_CARRIER   7
// Channel modes
`define SCI_MODE_ASYNC  2'h0
`define SCI_MODE_EXT    2'h1
`define SCI_MODE_INT    2'h2
// Clock factor codes and divisors
`define SCI_FAC_X1      2'h0
`define SCI_FAC_X16     2'h1
`define SCI_FAC_X32     2'h2
`define SCI_FAC_X64     2'h3
`define SCI_DIV_X1      7'h01
`define SCI_DIV_X16     7'h10
`define SCI_DIV_X32     7'h20
`define SCI_DIV_X64     7'h40
// Bits after the start bit: eight data plus one stop
`define SCI_TX_BITS     4'h9
`define SCI_RX_BITS     4'h9
`endif

// >>> src/sci_serial_channel.v
// Two serial channels with wait/ready, sync, modem-control pins.
// Assumes all channel pins are asynchronous to clk and slower than
// half its rate; the register port is on clk.
`timescale 1ns/1ps
`include "sci_map.vh"

// Function
// - Wait/ready pin role set by programming
// - Wait role: low stalls processor access
// - Ready role: low requests DMA transfer
// - Sync pin role follows channel mode
// - Receive clock divided by programmed factor in async mode, one clock per bit in sync modes
// - Transmit clock divided by programmed factor in async mode, one clock per bit in sync modes
// - Send request low while transmitting
// - Reception only while carrier detect low
// - Terminal ready follows software readiness
module sci_serial_channel (
  // Clock and reset
  input  wire                   clk,
  input  wire                   rst_n,
  // Register port
  input  wire [`SCI_ADDR_W-1:0] reg_addr,
  input  wire [`SCI_DATA_W-1:0] reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output wire [`SCI_DATA_W-1:0] reg_rdata,
  // Channel A pins
  output wire                   chan_a_wait_ready_out,
  input  wire                   chan_a_sync_pin_in,
  output wire                   chan_a_sync_pin_out,
  output wire                   chan_a_sync_pin_oe,
  input  wire                   chan_a_receive_clock,
  input  wire                   chan_a_transmit_clock,
  input  wire                   chan_a_serial_in,
  output wire                   chan_a_serial_out,
  output wire                   chan_a_terminal_ready,
  output wire                   chan_a_send_request,
  input  wire                   chan_a_send_clearance,
  input  wire                   chan_a_carrier_detect,
  // Channel B pins
  output wire                   chan_b_wait_ready_out,
  input  wire                   chan_b_sync_pin_in,
  output wire                   chan_b_sync_pin_out,
  output wire                   chan_b_sync_pin_oe,
  input  wire                   chan_b_receive_clock,
  input  wire                   chan_b_transmit_clock,
  input  wire                   chan_b_serial_in,
  output wire                   chan_b_serial_out,
  output wire                   chan_b_terminal_ready,
  output wire                   chan_b_send_request,
  input  wire                   chan_b_send_clearance,
  input  wire                   chan_b_carrier_detect
);

  // One-hot states
  localparam [1:0] TX_IDLE  = 2'b01;
  localparam [1:0] TX_SHIFT = 2'b10;
  localparam [2:0] RX_IDLE  = 3'b001;
  localparam [2:0] RX_START = 3'b010;
  localparam [2:0] RX_DATA  = 3'b100;

  // Address match for one register of one channel
  function sel;
    input [`SCI_ADDR_W-1:0] a;
    input                   ch;
    input [2:0]             r;
    begin
      sel = (a == {ch, r});
    end
  endfunction

  // Divisor for a clock factor code
  function [6:0] fac_div;
    input [1:0] f;
    begin
      case (f)
        `SCI_FAC_X16: fac_div = `SCI_DIV_X16;
        `SCI_FAC_X32: fac_div = `SCI_DIV_X32;
        `SCI_FAC_X64: fac_div = `SCI_DIV_X64;
        default:      fac_div = `SCI_DIV_X1;
      endcase
    end
  endfunction

  // Raw pins, six per channel, channel A in the low half
  wire [11:0] pin_raw = {chan_b_sync_pin_in, chan_b_carrier_detect,
                         chan_b_send_clearance, chan_b_serial_in,
                         chan_b_transmit_clock, chan_b_receive_clock,
                         chan_a_sync_pin_in, chan_a_carrier_detect,
                         chan_a_send_clearance, chan_a_serial_in,
                         chan_a_transmit_clock, chan_a_receive_clock};

  wire [15:0] rview;        // Read view per channel
  wire [1:0]  pin_sout;     // Serial out per channel
  wire [1:0]  pin_rts;      // Send request per channel
  wire [1:0]  pin_dtr;      // Terminal ready per channel
  wire [1:0]  pin_wr;       // Wait/ready per channel
  wire [1:0]  pin_syo;      // Sync pin level per channel
  wire [1:0]  pin_syoe;     // Sync pin enable per channel
  reg  [7:0]  rdata_ff;     // Read data, valid one cycle after strobe

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
      reg  [5:0] s1_ff;     // First sync stage, read only by s2_ff
      reg  [5:0] s2_ff;     // Second sync stage
      reg  [1:0] ck_d_ff;   // Delayed link clocks for edge finding
      reg  [7:0] ctrl_ff;   // Mode, factor, enables
      reg  [7:0] aux_ff;    // Wait/ready direction
      reg  [7:0] txbuf_ff;  // Pending transmit byte
      reg        txfull_ff; // Transmit byte pending
      reg  [1:0] txst_ff;   // Transmit state
      reg  [8:0] txsh_ff;   // Remaining data and stop
      reg  [3:0] txbits_ff; // Bits left to send
      reg  [5:0] txcnt_ff;  // Transmit prescaler
      reg        out_ff;    // Serial output
      reg  [2:0] rxst_ff;   // Receive state
      reg  [7:0] rxsh_ff;   // Receive shifter
      reg  [3:0] rxbits_ff; // Samples taken after start
      reg  [5:0] rxcnt_ff;  // Receive prescaler
      reg  [7:0] rxbuf_ff;  // Received byte
      reg        rxfull_ff; // Received byte unread
      reg        ovr_ff;    // Overrun, sticky
      reg        frm_ff;    // Framing error, sticky
      reg        rts_ff;    // Send request pin, active low
      reg        dtr_ff;    // Terminal ready pin, active low
      reg        wr_ff;     // Wait/ready pin, active low
      reg        syo_ff;    // Sync pin drive level
      reg        syoe_ff;   // Sync pin drive enable
      reg  [7:0] rv;        // Read view mux

      wire       rxc_s = s2_ff[0];
      wire       txc_s = s2_ff[1];
      wire       rxd_s = s2_ff[2];
      wire       cts_s = s2_ff[3];
      wire       dcd_s = s2_ff[4];
      wire       syn_s = s2_ff[5];
      wire [1:0] mode  = ctrl_ff[`SCI_C_MODE_LO +: 2];
      // Sync modes run at one clock per bit
      wire [1:0] fac   = (mode == `SCI_MODE_ASYNC) ?
                         ctrl_ff[`SCI_C_FAC_LO +: 2] : `SCI_FAC_X1;
      wire [6:0] div   = fac_div(fac);
      wire [5:0] last  = div[5:0] - 6'h01;
      wire [5:0] half  = div[6:1] - 6'h01;
      wire       rx_tick = rxc_s & ~ck_d_ff[0];
      wire       tx_tick = ~txc_s & ck_d_ff[1];
      wire       rx_ok = ctrl_ff[`SCI_C_RXEN] & ~dcd_s &
                         ((mode != `SCI_MODE_EXT) | ~syn_s);
      wire       wr_ctl = reg_wr & sel(reg_addr, g == 1, `SCI_REG_CTRL);
      wire       wr_aux = reg_wr & sel(reg_addr, g == 1, `SCI_REG_AUX);
      wire       wr_tx  = reg_wr & sel(reg_addr, g == 1, `SCI_REG_TXDATA);
      wire       wr_st  = reg_wr & sel(reg_addr, g == 1, `SCI_REG_STATUS);
      wire       rd_rx  = reg_rd & sel(reg_addr, g == 1, `SCI_REG_RXDATA);
      wire       tx_load = tx_tick & txst_ff[0] & txfull_ff & ~cts_s;
      wire       rx_done = rx_tick & rxst_ff[2] & (rxcnt_ff == last) &
                           (rxbits_ff == `SCI_RX_BITS - 4'h1) & rx_ok;

      // Two-stage synchronisers, then edge history on stage two
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_ff   <= 6'h3f;
          s2_ff   <= 6'h3f;
          ck_d_ff <= 2'h3;
        end else begin
          s1_ff   <= pin_raw[g*6 +: 6];
          s2_ff   <= s1_ff;
          ck_d_ff <= s2_ff[1:0];
        end
      end

      // Software registers; a write while full replaces the byte
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ctrl_ff   <= `SCI_CTRL_RST;
          aux_ff    <= `SCI_AUX_RST;
          txbuf_ff  <= 8'h00;
          txfull_ff <= 1'b0;
        end else begin
          if (wr_ctl)
            ctrl_ff <= reg_wdata;
          if (wr_aux)
            aux_ff <= reg_wdata;
          if (wr_tx)
            txbuf_ff <= reg_wdata;
          // New byte wins over the load that empties the buffer
          if (wr_tx)
            txfull_ff <= 1'b1;
          else if (tx_load)
            txfull_ff <= 1'b0;
        end
      end

      // Transmitter; a character once begun always finishes
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          txst_ff   <= TX_IDLE;
          txsh_ff   <= 9'h1ff;
          txbits_ff <= 4'h0;
          txcnt_ff  <= 6'h00;
          out_ff    <= 1'b1;
        end else begin
          case (txst_ff)
            TX_IDLE: begin
              if (tx_load) begin
                out_ff    <= 1'b0;
                txsh_ff   <= {1'b1, txbuf_ff};
                txbits_ff <= `SCI_TX_BITS;
                txcnt_ff  <= 6'h00;
                txst_ff   <= TX_SHIFT;
              end
            end
            TX_SHIFT: begin
              if (tx_tick) begin
                if (txcnt_ff != last) begin
                  txcnt_ff <= txcnt_ff + 6'h01;
                end else begin
                  txcnt_ff <= 6'h00;
                  if (txbits_ff == 4'h0) begin
                    txst_ff <= TX_IDLE;
                  end else begin
                    out_ff    <= txsh_ff[0];
                    txsh_ff   <= {1'b1, txsh_ff[8:1]};
                    txbits_ff <= txbits_ff - 4'h1;
                  end
                end
              end
            end
            default: txst_ff <= TX_IDLE;
          endcase
        end
      end

      // Receiver; loss of carrier abandons the character
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          rxst_ff   <= RX_IDLE;
          rxsh_ff   <= 8'h00;
          rxbits_ff <= 4'h0;
          rxcnt_ff  <= 6'h00;
        end else if (!rx_ok) begin
          rxst_ff <= RX_IDLE;
        end else begin
          case (rxst_ff)
            RX_IDLE: begin
              if (rx_tick && !rxd_s) begin
                rxcnt_ff  <= 6'h00;
                rxbits_ff <= 4'h0;
                // At one clock per bit the start is taken as seen
                rxst_ff   <= (fac == `SCI_FAC_X1) ? RX_DATA : RX_START;
              end
            end
            RX_START: begin
              if (rx_tick) begin
                if (rxcnt_ff != half) begin
                  rxcnt_ff <= rxcnt_ff + 6'h01;
                end else begin
                  rxcnt_ff <= 6'h00;
                  rxst_ff  <= rxd_s ? RX_IDLE : RX_DATA;
                end
              end
            end
            RX_DATA: begin
              if (rx_tick) begin
                if (rxcnt_ff != last) begin
                  rxcnt_ff <= rxcnt_ff + 6'h01;
                end else begin
                  rxcnt_ff  <= 6'h00;
                  rxbits_ff <= rxbits_ff + 4'h1;
                  if (rxbits_ff < `SCI_RX_BITS - 4'h1)
                    rxsh_ff <= {rxd_s, rxsh_ff[7:1]};
                  else
                    rxst_ff <= RX_IDLE;
                end
              end
            end
            default: rxst_ff <= RX_IDLE;
          endcase
        end
      end

      // Receive buffer and sticky errors; hardware set beats clear
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          rxbuf_ff  <= 8'h00;
          rxfull_ff <= 1'b0;
          ovr_ff    <= 1'b0;
          frm_ff    <= 1'b0;
        end else begin
          if (rx_done)
            rxbuf_ff <= rxsh_ff;
          if (rx_done)
            rxfull_ff <= 1'b1;
          else if (rd_rx)
            rxfull_ff <= 1'b0;
          if (rx_done && rxfull_ff && !rd_rx)
            ovr_ff <= 1'b1;
          else if (wr_st && reg_wdata[`SCI_S_OVR])
            ovr_ff <= 1'b0;
          if (rx_done && !rxd_s)
            frm_ff <= 1'b1;
          else if (wr_st && reg_wdata[`SCI_S_FRM])
            frm_ff <= 1'b0;
        end
      end

      // Handshake and sync pins, all registered
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          rts_ff  <= 1'b1;
          dtr_ff  <= 1'b1;
          wr_ff   <= 1'b1;
          syo_ff  <= 1'b1;
          syoe_ff <= 1'b0;
        end else begin
          rts_ff <= ~(txst_ff[1] | txfull_ff);
          dtr_ff <= ~ctrl_ff[`SCI_C_DTR];
          if (!ctrl_ff[`SCI_C_WREN])
            wr_ff <= 1'b1;
          else if (ctrl_ff[`SCI_C_WRFN])
            wr_ff <= ~(aux_ff[`SCI_A_WRDIR] ? rxfull_ff : ~txfull_ff);
          else
            wr_ff <= ~(aux_ff[`SCI_A_WRDIR] ? ~rxfull_ff : txfull_ff);
          syoe_ff <= (mode == `SCI_MODE_INT);
          // Low for one receive clock after each character
          if (rx_done)
            syo_ff <= 1'b0;
          else if (rx_tick)
            syo_ff <= 1'b1;
        end
      end

      // Read view; unused indices read as zero
      always @* begin
        rv = 8'h00;
        case (reg_addr[2:0])
          `SCI_REG_CTRL:   rv = ctrl_ff;
          `SCI_REG_TXDATA: rv = txbuf_ff;
          `SCI_REG_RXDATA: rv = rxbuf_ff;
          `SCI_REG_STATUS: rv = {dcd_s, cts_s, frm_ff, ovr_ff,
                                 ~rxst_ff[0], txst_ff[1],
                                 rxfull_ff, txfull_ff};
          `SCI_REG_AUX:    rv = {6'h00, syn_s, aux_ff[`SCI_A_WRDIR]};
          default:         rv = 8'h00;
        endcase
      end

      assign rview[g*8 +: 8] = rv;
      assign pin_sout[g]     = out_ff;
      assign pin_rts[g]      = rts_ff;
      assign pin_dtr[g]      = dtr_ff;
      assign pin_wr[g]       = wr_ff;
      assign pin_syo[g]      = syo_ff;
      assign pin_syoe[g]     = syoe_ff;
    end
  endgenerate

  // Read data stand only in the cycle after the strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rdata_ff <= 8'h00;
    else if (reg_rd)
      rdata_ff <= reg_addr[3] ? rview[15:8] : rview[7:0];
    else
      rdata_ff <= 8'h00;
  end

  assign reg_rdata             = rdata_ff;
  assign chan_a_serial_out     = pin_sout[0];
  assign chan_b_serial_out     = pin_sout[1];
  assign chan_a_send_request   = pin_rts[0];
  assign chan_b_send_request   = pin_rts[1];
  assign chan_a_terminal_ready = pin_dtr[0];
  assign chan_b_terminal_ready = pin_dtr[1];
  assign chan_a_wait_ready_out = pin_wr[0];
  assign chan_b_wait_ready_out = pin_wr[1];
  assign chan_a_sync_pin_out   = pin_syo[0];
  assign chan_b_sync_pin_out   = pin_syo[1];
  assign chan_a_sync_pin_oe    = pin_syoe[0];
  assign chan_b_sync_pin_oe    = pin_syoe[1];

endmodule // sci_serial_channel

// >>> verif/sci_modem_model.sv
// Far-side modem model for one channel: link clocks, line, handshakes.
// Assumes the channel samples these pins with a far faster clock.
`timescale 1ns/1ps

module sci_modem_model (
  output reg  rx_clk,     // Receive clock to the channel
  output reg  tx_clk,     // Transmit clock to the channel
  output reg  line_out,   // Serial data to the channel
  input  wire line_in,    // Serial data from the channel
  output reg  clear_n,    // Clearance to send, active low
  output reg  carrier_n,  // Carrier present, active low
  output wire sync_in,    // Resolved sync pin level
  input  wire sync_out,
  input  wire sync_oe
);
  reg txc_on, rxc_on;  // Clocks stand still unless a task runs them
  reg sync_drv;        // Pull-up level unless a test pulls low

  assign sync_in = sync_oe ? sync_out : sync_drv;

  initial begin
    {rx_clk, tx_clk, txc_on, rxc_on, clear_n, carrier_n} = 6'h00;
    {line_out, sync_drv} = 2'h3;
  end

  // 160 ns link clocks, offset from the system clock
  initial begin
    #3;
    forever begin
      #80;
      if (txc_on) tx_clk = ~tx_clk;
      if (rxc_on) rx_clk = ~rx_clk;
    end
  end

  // Run the transmit clock with no frame expected
  task run_tx(input integer n);
    begin
      txc_on = 1'b1;
      repeat (n) @(posedge tx_clk);
      txc_on = 1'b0;
    end
  endtask

  // find start, sample mid-cell, n clocks a bit, LSB first
  task recv_byte(input integer n, output [7:0] b);
    integer i, k;
    begin
      txc_on = 1'b1;
      k = 0;
      do begin
        @(posedge tx_clk);
        k = k + 1;
      end while (line_in !== 1'b0 && k < 300);
      repeat (n / 2) @(posedge tx_clk);
      for (i = 0; i < 8; i = i + 1) begin
        repeat (n) @(posedge tx_clk);
        b[i] = line_in;
      end
      repeat (n + n / 2 + 2) @(posedge tx_clk);
      txc_on = 1'b0;
    end
  endtask

  // one frame, n clocks a bit, changed on falling edges
  task send_byte(input [7:0] b, input integer n);
    reg [9:0] fr;
    integer i;
    begin
      fr = {1'b1, b, 1'b0};
      rxc_on = 1'b1;
      for (i = 0; i < 10; i = i + 1) begin
        @(negedge rx_clk);
        line_out = fr[i];
        repeat (n - 1) @(negedge rx_clk);
      end
      repeat (2) @(negedge rx_clk);
      rxc_on = 1'b0;
    end
  endtask
endmodule // sci_modem_model

// >>> verif/sci_serial_channel_asserts.sv
// Port checker for the two-channel serial pin block.
// Assumes it is bound into the block and sees only its ports.
`timescale 1ns/1ps
`include "sci_map.vh"

module sci_serial_channel_asserts (
  // Clock, reset, register port
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins under watch
  input wire logic       chan_a_serial_out,
  input wire logic       chan_a_send_request,
  input wire logic       chan_a_terminal_ready,
  input wire logic       chan_a_sync_pin_oe,
  input wire logic       chan_a_wait_ready_out,
  input wire logic       chan_b_serial_out,
  input wire logic       chan_b_send_request,
  input wire logic       chan_b_terminal_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Control writes; a quiet cycle after one lets the pins settle
  wire ctl_wr_a = reg_wr && reg_addr == 4'h0;
  wire ctl_wr_b = reg_wr && reg_addr == 4'h8;

  a_rts_line_a: assert property (
    !chan_a_serial_out |-> !chan_a_send_request) else $error("rts a");
  a_rts_line_b: assert property (
    !chan_b_serial_out |-> !chan_b_send_request) else $error("rts b");
  a_dtr_level_a: assert property (ctl_wr_a ##1 !ctl_wr_a |=>
    chan_a_terminal_ready == !$past(reg_wdata[5], 2)) else $error("dtr a");
  a_dtr_level_b: assert property (ctl_wr_b ##1 !ctl_wr_b |=>
    chan_b_terminal_ready == !$past(reg_wdata[5], 2)) else $error("dtr b");
  a_sync_dir_a: assert property (ctl_wr_a ##1 !ctl_wr_a |=>
    chan_a_sync_pin_oe == ($past(reg_wdata[1:0], 2) == `SCI_MODE_INT))
    else $error("sync dir a");
  a_wait_off_a: assert property (
    ctl_wr_a && !reg_wdata[`SCI_C_WREN] ##1 !ctl_wr_a |=>
    chan_a_wait_ready_out) else $error("wait off a");
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("rdata idle");
  a_unmapped_rd: assert property (
    reg_rd && reg_addr[2:0] > 3'h4 |=> reg_rdata == 8'h00)
    else $error("unmapped read");

  c_tx_start: cover property ($fell(chan_a_serial_out));
  c_wait_low: cover property (!chan_a_wait_ready_out);
  c_sync_out: cover property (chan_a_sync_pin_oe);
endmodule // sci_serial_channel_asserts

bind sci_serial_channel sci_serial_channel_asserts sci_chk (
  .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .chan_a_serial_out, .chan_a_send_request, .chan_a_terminal_ready,
  .chan_a_sync_pin_oe, .chan_a_wait_ready_out, .chan_b_serial_out,
  .chan_b_send_request, .chan_b_terminal_ready);

// >>> verif/sci_serial_channel_tb.sv
// Self-checking bench for the two-channel serial pin block.
// Assumes a modem model on each channel and the bound checker.
`timescale 1ns/1ps

module sci_serial_channel_tb;
  reg        clk, rst_n, reg_wr, reg_rd;  // Clock, reset, strobes
  reg  [3:0] reg_addr;                    // {channel, index}
  reg  [7:0] reg_wdata, got;              // Write data, last read
  wire [7:0] reg_rdata;
  integer    n_mismatch, check_count, i;
  reg  [1:0] so_low;                      // Sync drive seen low, {b, a}
  // Channel pins; _n marks active-low lines
  wire a_wr_n, a_si, a_so, a_oe, a_rxc, a_txc, a_sin, a_sout, a_dtr_n;
  wire a_rts_n, a_cts_n, a_dcd_n, b_wr_n, b_si, b_so, b_oe, b_rxc, b_txc;
  wire b_sin, b_sout, b_dtr_n, b_rts_n, b_cts_n, b_dcd_n;

  sci_serial_channel sci_serial_channel_inst (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chan_a_wait_ready_out(a_wr_n), .chan_a_sync_pin_in(a_si),
    .chan_a_sync_pin_out(a_so), .chan_a_sync_pin_oe(a_oe),
    .chan_a_receive_clock(a_rxc), .chan_a_transmit_clock(a_txc),
    .chan_a_serial_in(a_sin), .chan_a_serial_out(a_sout),
    .chan_a_terminal_ready(a_dtr_n), .chan_a_send_request(a_rts_n),
    .chan_a_send_clearance(a_cts_n), .chan_a_carrier_detect(a_dcd_n),
    .chan_b_wait_ready_out(b_wr_n), .chan_b_sync_pin_in(b_si),
    .chan_b_sync_pin_out(b_so), .chan_b_sync_pin_oe(b_oe),
    .chan_b_receive_clock(b_rxc), .chan_b_transmit_clock(b_txc),
    .chan_b_serial_in(b_sin), .chan_b_serial_out(b_sout),
    .chan_b_terminal_ready(b_dtr_n), .chan_b_send_request(b_rts_n),
    .chan_b_send_clearance(b_cts_n), .chan_b_carrier_detect(b_dcd_n));

  sci_modem_model mdm_a (.rx_clk(a_rxc), .tx_clk(a_txc), .line_out(a_sin),
    .line_in(a_sout), .clear_n(a_cts_n), .carrier_n(a_dcd_n),
    .sync_in(a_si), .sync_out(a_so), .sync_oe(a_oe));
  sci_modem_model mdm_b (.rx_clk(b_rxc), .tx_clk(b_txc), .line_out(b_sin),
    .line_in(b_sout), .clear_n(b_cts_n), .carrier_n(b_dcd_n),
    .sync_in(b_si), .sync_out(b_so), .sync_oe(b_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Latch any low on the sync drive levels once reset is gone
  always @(posedge clk)
    if (rst_n)
      so_low <= so_low | {~b_so, ~a_so};

  task chk(input [7:0] g, input [7:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  // One-cycle write strobe; strobes never overlap
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask

  // Read data stands only in the cycle after the strobe
  task rdc(input [3:0] a, input [7:0] m, input [7:0] e);
    begin
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 got = reg_rdata;
      chk(got & m, e);
    end
  endtask

  // Let edges pass and their updates land
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask

  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  initial begin
    {n_mismatch, check_count} = 0;
    so_low = 2'h0;
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = 15'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    chk({3'h0, a_sout, a_rts_n, a_dtr_n, a_wr_n, a_oe}, 8'h1e);
    chk({3'h0, b_sout, b_rts_n, b_dtr_n, b_wr_n, b_oe}, 8'h1e);
    rdc(4'h0, 8'hff, 8'h00);
    rdc(4'h4, 8'hff, 8'h02);
    wr(4'h6, 8'hff);
    rdc(4'h6, 8'hff, 8'h00);
    $display("test reset and map done");
    // Terminal ready and sync direction on both channels, internal and external sync modes
    for (i = 0; i < 2; i = i + 1) begin
      wr({i[0], 3'h0}, 8'h22);
      tick(3);
      chk({6'h0, i ? b_dtr_n : a_dtr_n, i ? b_oe : a_oe}, 8'h01);
      wr({i[0], 3'h0}, 8'h01);
      tick(3);
      chk({6'h0, i ? b_dtr_n : a_dtr_n, i ? b_oe : a_oe}, 8'h02);
    end
    mdm_a.sync_drv <= 1'b0;
    tick(4);
    rdc(4'h4, 8'hff, 8'h00);
    mdm_a.sync_drv <= 1'b1;
    $display("test terminal ready and sync done");
    // Byte held back by clearance; wait, then ready function
    mdm_a.clear_n <= 1'b1;
    wr(4'h0, 8'h40);
    wr(4'h1, 8'h3c);
    tick(3);
    chk({6'h0, a_wr_n, a_rts_n}, 8'h00);
    rdc(4'h3, 8'hff, 8'h41);
    mdm_a.run_tx(8);
    chk({7'h0, a_sout}, 8'h01);
    wr(4'h0, 8'hc0);
    tick(3);
    chk({7'h0, a_wr_n}, 8'h01);
    mdm_a.clear_n <= 1'b0;
    mdm_a.recv_byte(1, got);
    chk(got, 8'h3c);
    tick(3);
    chk({6'h0, a_rts_n, a_wr_n}, 8'h02);
    // Transmit at every larger clock factor
    for (i = 1; i < 4; i = i + 1) begin
      wr(4'h0, {4'h0, i[1:0], 2'h0});
      wr(4'h1, 8'h5a ^ i[7:0]);
      mdm_a.recv_byte(1 << (i + 3), got);
      chk(got, 8'h5a ^ i[7:0]);
    end
    $display("test transmit done");
    // Receive at every clock factor, then with carrier lost
    for (i = 0; i < 4; i = i + 1) begin
      wr(4'h8, {4'h1, i[1:0], 2'h0});
      mdm_b.send_byte(8'hc3 ^ i[7:0], i ? 1 << (i + 3) : 1);
      tick(3);
      rdc(4'ha, 8'hff, 8'hc3 ^ i[7:0]);
    end
    chk({6'h0, so_low}, 8'h02);
    // Back to one clock per bit, so a byte would land if carrier leaked
    wr(4'h8, 8'h10);
    mdm_b.carrier_n <= 1'b1;
    mdm_b.send_byte(8'h99, 1);
    tick(3);
    rdc(4'hb, 8'h82, 8'h80);
    $display("test receive done");
    // Channel B sends once so its send-request path is exercised
    wr(4'h9, 8'h81);
    mdm_b.recv_byte(1, got);
    chk(got, 8'h81);
    $display("test channel b transmit done");
    wrap_up;
  end

  // Whole run is near 0.4 ms; stop a hang at 0.9 ms, over twice that
  initial begin
    #900_000;
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end
endmodule // sci_serial_channel_tb
